// file: rtl/sfb_status_bank.sv
`timescale 1ns/1ps
// Status flags, bank selector and data bank decode of the processor core.
module sfb_status_bank #(
  parameter int GPR_PER_BANK = sfb_pkg::GPR_BYTES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Register bus slave.
  input wire logic [sfb_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sfb_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Execution datapath operation.
  input wire logic op_valid,
  input wire sfb_pkg::sfb_op_t op_code,
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  output logic [7:0] alu_result,
  // Direct writes of the status register and bank selector by instructions.
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  input wire logic bank_wr,
  input wire logic [4:0] bank_wdata,
  // Watchdog and power events, one-cycle pulses.
  input wire logic watchdog_expire,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic other_reset,
  input wire logic other_reset_by_watchdog,
  input wire logic other_reset_in_sleep,
  // Data memory address decode.
  input wire logic [6:0] mem_offset,
  input wire logic mem_use_linear,
  input wire logic [11:0] mem_lin_index,
  output sfb_pkg::sfb_region_t mem_region,
  output logic [4:0] mem_bank,
  output logic [6:0] mem_eff_offset,
  output logic [11:0] mem_gpr_index,
  output logic [7:0] mem_core_rdata,
  output logic [7:0] core_status_flags,
  output logic [4:0] bank_selector
);
  import sfb_pkg::*;

  logic [7:0] status_reg; // Status flags, bits seven to five always zero.
  logic [7:0] status_next;
  logic [4:0] bank_reg; // Active bank number.
  logic [4:0] bank_next;
  logic [7:0] result_reg; // Last operation result.
  logic [7:0] result_next;
  logic aw_held_reg; // Write address taken and waiting.
  logic aw_held_next;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_next;
  logic w_held_reg; // Write data taken and waiting.
  logic w_held_next;
  logic [7:0] w_data_reg;
  logic [7:0] w_data_next;
  logic w_strb_reg;
  logic w_strb_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  sfb_region_t region_reg; // Registered decode results.
  sfb_region_t region_next;
  logic [4:0] mbank_reg;
  logic [4:0] mbank_next;
  logic [6:0] moffs_reg;
  logic [6:0] moffs_next;
  logic [11:0] gidx_reg;
  logic [11:0] gidx_next;
  logic [7:0] core_rd_reg;
  logic [7:0] core_rd_next;
  // Decoder outputs before registering.
  sfb_region_t dec_region;
  logic [4:0] dec_bank;
  logic [6:0] dec_offset;
  logic [11:0] dec_gidx;
  // Bus strobes.
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  // Arithmetic working values.
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] alu_val;

  // Ready outputs are combinational; the clock enable stalls the bus as well.
  assign s_axi_awready = clk_en && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = clk_en && !w_held_reg && !bvalid_reg;
  assign s_axi_arready = clk_en && !rvalid_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  // A write commits in the first cycle in which both address and data are held.
  assign do_write = clk_en && aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign alu_result = result_reg;
  assign core_status_flags = status_reg;
  assign bank_selector = bank_reg;
  assign mem_region = region_reg;
  assign mem_bank = mbank_reg;
  assign mem_eff_offset = moffs_reg;
  assign mem_gpr_index = gidx_reg;
  assign mem_core_rdata = core_rd_reg;

  // Adder shared by add and subtract; subtraction adds the inverted operand plus one.
  always_comb begin
    if (op_code == SFB_OP_SUB) begin
      sum9 = {1'b0, op_a} + {1'b0, ~op_b} + 9'h001; // [RQ10]
      nib5 = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + 5'h01; // [RQ10]
    end else begin
      sum9 = {1'b0, op_a} + {1'b0, op_b};
      nib5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
    end
    case (op_code)
      SFB_OP_ADD, SFB_OP_SUB: alu_val = sum9[7:0];
      SFB_OP_ROTR: alu_val = {status_reg[STAT_C_BIT], op_a[7:1]};
      SFB_OP_ROTL: alu_val = {op_a[6:0], status_reg[STAT_C_BIT]};
      default: alu_val = op_a;
    endcase
  end

  // Next status value: direct writes first, then flag updates, then wake events.
  always_comb begin
    status_next = status_reg;
    result_next = result_reg;
    if (clk_en) begin
      // Writes reach only the arithmetic flags, and only if no flag update competes. [RQ17]
      if (!op_valid) begin
        if (status_wr) begin
          status_next = (status_reg & ~STAT_ARITH_MASK) | (status_wdata & STAT_ARITH_MASK);
        end else if (do_write && aw_addr_reg == REG_STATUS_OFS && w_strb_reg) begin
          status_next = (status_reg & ~STAT_ARITH_MASK) | (w_data_reg & STAT_ARITH_MASK);
        end
      end
      // Flags an operation does not touch keep their value. [RQ21]
      if (op_valid) begin
        result_next = alu_val;
        case (op_code)
          SFB_OP_ADD, SFB_OP_SUB: begin
            status_next[STAT_Z_BIT] = (sum9[7:0] == 8'h00); // [RQ6]
            status_next[STAT_NIB_BIT] = nib5[4]; // [RQ7] [RQ9]
            status_next[STAT_C_BIT] = sum9[8]; // [RQ8] [RQ9]
          end
          SFB_OP_ROTR: status_next[STAT_C_BIT] = op_a[0]; // [RQ11]
          SFB_OP_ROTL: status_next[STAT_C_BIT] = op_a[7]; // [RQ11]
          default: status_next[STAT_Z_BIT] = (op_a == 8'h00); // [RQ6]
        endcase
      end
      // Sleep and watchdog clear raise the expiry flag; an expiry in the same cycle wins.
      if (watchdog_clear_instr || sleep_instr) begin
        status_next[STAT_TO_BIT] = 1'b1; // [RQ2]
      end
      if (watchdog_expire) begin
        status_next[STAT_TO_BIT] = 1'b0; // [RQ3]
      end
      if (watchdog_clear_instr) begin
        status_next[STAT_SLEEP_BIT] = 1'b1; // [RQ4]
      end
      if (sleep_instr) begin
        status_next[STAT_SLEEP_BIT] = 1'b0; // [RQ5]
      end
      // Other resets set wake flags from their cause and keep the arithmetic flags.
      if (other_reset) begin
        status_next[STAT_TO_BIT] = !other_reset_by_watchdog; // [RQ12]
        status_next[STAT_SLEEP_BIT] = !other_reset_in_sleep; // [RQ12]
      end
      status_next[7:5] = 3'h0; // [RQ1]
    end
  end

  // Status and result registers; power-on reset gives the fixed pattern.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= STAT_POR_VALUE; // [RQ12]
      result_reg <= 8'h00;
    end else begin
      status_reg <= status_next;
      result_reg <= result_next;
    end
  end

  // Bank selector: datapath writes take priority over bus writes.
  always_comb begin
    bank_next = bank_reg;
    if (clk_en) begin
      if (bank_wr) begin
        bank_next = bank_wdata; // [RQ18]
      end else if (do_write && aw_addr_reg == REG_BANKSEL_OFS && w_strb_reg) begin
        bank_next = w_data_reg[4:0]; // [RQ18]
      end
    end
  end

  // Bank selector register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_reg <= BANK_SEL_RESET;
    end else begin
      bank_reg <= bank_next;
    end
  end

  // Write channel: hold address and data independently, then answer once.
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (clk_en) begin
      if (aw_take) begin
        aw_held_next = 1'b1;
        aw_addr_next = s_axi_awaddr;
      end
      if (w_take) begin
        w_held_next = 1'b1;
        w_data_next = s_axi_wdata[7:0];
        w_strb_next = s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_next = 1'b0;
        w_held_next = 1'b0;
        bvalid_next = 1'b1;
        // Status and bank selector accept writes; the result register is read-only.
        if (aw_addr_reg == REG_STATUS_OFS || aw_addr_reg == REG_BANKSEL_OFS) begin
          bresp_next = RESP_OKAY;
        end else begin
          bresp_next = RESP_SLVERR;
        end
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_next = 1'b0;
      end
    end
  end

  // Read channel: data is captured when the address is taken.
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (clk_en) begin
      if (ar_take) begin
        rvalid_next = 1'b1;
        rresp_next = RESP_OKAY;
        case (s_axi_araddr)
          REG_STATUS_OFS: rdata_next = {24'h000000, status_reg}; // [RQ1]
          REG_BANKSEL_OFS: rdata_next = {27'h0000000, bank_reg};
          REG_RESULT_OFS: rdata_next = {24'h000000, result_reg};
          default: begin
            rdata_next = 32'h00000000;
            rresp_next = RESP_SLVERR;
          end
        endcase
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_next = 1'b0;
      end
    end
  end

  // Bus registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Address decode of the current bank and offset.
  sfb_bank_decode #(
    .GPR_PER_BANK(GPR_PER_BANK)
  ) u_decode (
    .bank(bank_reg),
    .offset(mem_offset),
    .use_linear(mem_use_linear),
    .lin_index(mem_lin_index),
    .region(dec_region),
    .eff_bank(dec_bank),
    .eff_offset(dec_offset),
    .gpr_index(dec_gidx)
  );

  // Decode results and core read data are registered one cycle after the request.
  always_comb begin
    region_next = region_reg;
    mbank_next = mbank_reg;
    moffs_next = moffs_reg;
    gidx_next = gidx_reg;
    core_rd_next = core_rd_reg;
    if (clk_en) begin
      region_next = dec_region;
      mbank_next = dec_bank;
      moffs_next = dec_offset;
      gidx_next = dec_gidx;
      core_rd_next = 8'h00; // [RQ19]
      if (dec_region == SFB_REG_CORE && dec_offset[3:0] == CORE_STATUS_IDX) begin
        core_rd_next = status_reg; // [RQ20]
      end else if (dec_region == SFB_REG_CORE && dec_offset[3:0] == CORE_BANKSEL_IDX) begin
        core_rd_next = {3'h0, bank_reg};
      end
    end
  end

  // Decode registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      region_reg <= SFB_REG_CORE;
      mbank_reg <= 5'h00;
      moffs_reg <= 7'h00;
      gidx_reg <= 12'h000;
      core_rd_reg <= 8'h00;
    end else begin
      region_reg <= region_next;
      mbank_reg <= mbank_next;
      moffs_reg <= moffs_next;
      gidx_reg <= gidx_next;
      core_rd_reg <= core_rd_next;
    end
  end

  default clocking dflt_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Helper: a cycle with no event that may change the arithmetic flags.
  logic flags_quiet;
  assign flags_quiet = clk_en && !op_valid && !status_wr && !do_write;

  a_top_bits_zero: assert property (ar_take && s_axi_araddr == REG_STATUS_OFS |=> // [RQ1]
    status_reg[7:5] == 3'h0 && rdata_reg[31:5] == '0) else $error("status upper bits not zero");
  a_clear_sets_to: assert property (clk_en && (watchdog_clear_instr || sleep_instr) && !watchdog_expire // [RQ2]
    && !other_reset |=> status_reg[STAT_TO_BIT]) else $error("expiry flag not set");
  a_expire_clears: assert property (clk_en && watchdog_expire && !other_reset |=> !status_reg[STAT_TO_BIT]) // [RQ3]
    else $error("expiry flag not cleared");
  a_clear_sets_sleep: assert property (clk_en && watchdog_clear_instr && !sleep_instr && !other_reset // [RQ4]
    |=> status_reg[STAT_SLEEP_BIT]) else $error("sleep flag not set");
  a_sleep_clears: assert property (clk_en && sleep_instr && !other_reset |=> !status_reg[STAT_SLEEP_BIT]) // [RQ5]
    else $error("sleep flag not cleared");
  a_add_flags: assert property (clk_en && op_valid && op_code == SFB_OP_ADD |=> // [RQ6] [RQ7] [RQ8]
    status_reg[STAT_C_BIT] == (({1'b0, $past(op_a)} + {1'b0, $past(op_b)}) > 9'h0FF)
    && status_reg[STAT_Z_BIT] == (alu_result == 8'h00)
    && status_reg[STAT_NIB_BIT] == (({1'b0, $past(op_a[3:0])} + {1'b0, $past(op_b[3:0])}) > 5'h0F))
    else $error("add flags wrong");
  a_sub_borrow: assert property (clk_en && op_valid && op_code == SFB_OP_SUB |=> // [RQ9] [RQ10]
    status_reg[STAT_C_BIT] == ($past(op_a) >= $past(op_b)) && alu_result == 8'($past(op_a) - $past(op_b)))
    else $error("subtract borrow wrong");
  a_rotate_carry: assert property (clk_en && op_valid && op_code inside {SFB_OP_ROTR, SFB_OP_ROTL} |=> // [RQ11]
    status_reg[STAT_C_BIT] == ($past(op_code) == SFB_OP_ROTR ? $past(op_a[0]) : $past(op_a[7])))
    else $error("rotate carry wrong");
  a_hold_flags: assert property (flags_quiet [*2] |=> $stable(status_reg[2:0])) // [RQ21]
    else $error("flags changed without cause");
  // The reset check must not be switched off by the very reset it watches.
  a_por_value: assert property (@(posedge aclk) disable iff (1'b0) !aresetn // [RQ12]
    |=> status_reg == STAT_POR_VALUE) else $error("reset status value wrong");
  a_wake_readonly: assert property (clk_en && status_wr && !op_valid && !watchdog_expire // [RQ17]
    && !watchdog_clear_instr && !sleep_instr && !other_reset |=> $stable(status_reg[4:3])
    && status_reg[2:0] == $past(status_wdata[2:0])) else $error("status write misbehaved");
  a_bank_select: assert property (clk_en && bank_wr |=> bank_reg == $past(bank_wdata)) // [RQ18]
    else $error("bank not selected");
  a_region_map: assert property (clk_en && !mem_use_linear |=> // [RQ13] [RQ16]
    (mem_region == SFB_REG_PERIPH) == ($past(mem_offset) inside {[PERIPH_FIRST:PERIPH_LAST]})
    && (mem_region == SFB_REG_COMMON) == ($past(mem_offset) >= COMMON_FIRST))
    else $error("bank region wrong");
  a_unimpl_zero: assert property (region_reg != SFB_REG_CORE |-> core_rd_reg == 8'h00) // [RQ19]
    else $error("unimplemented read not zero");

  c_add_carry: cover property (clk_en && op_valid && op_code == SFB_OP_ADD ##1 status_reg[STAT_C_BIT]);
  c_sleep_then_expire: cover property (clk_en && sleep_instr ##[1:20] clk_en && watchdog_expire);
  c_bus_write: cover property (s_axi_bvalid && s_axi_bready);
  c_linear_gpr: cover property (clk_en && mem_use_linear ##1 mem_region == SFB_REG_GPR);
endmodule

// file: shared/sfb_pkg.sv
// Overview of operation
// RQ1 - Status bits seven to five read zero.
// RQ2 - Power-up, watchdog clear, sleep set expiry flag.
// RQ3 - Watchdog expiry clears the expiry flag.
// RQ4 - Power-up or watchdog clear sets sleep flag.
// RQ5 - Sleep instruction clears the sleep flag.
// RQ6 - Zero flag follows all-zero operation result.
// RQ7 - Add/subtract set nibble carry from bit four.
// RQ8 - Add/subtract set carry from top bit.
// RQ9 - Subtract carries mean no borrow when one.
// RQ10 - Subtract adds two's complement of operand.
// RQ11 - Rotates load carry from low/high source bit.
// RQ12 - Power-on resets wake ones, arithmetic zeros.
// RQ13 - Peripheral area is bank offsets 0x0C-0x1F.
// RQ14 - Up to 80 general RAM bytes per bank.
// RQ15 - General RAM also reachable as linear region.
// RQ16 - Sixteen common bytes decode in every bank.
// RQ17 - Flag-updating writes skip flags; wake read-only.
// RQ18 - Thirty-two banks of 128, chosen by selector.
// RQ19 - Unimplemented data locations read as zero.
// RQ20 - First twelve offsets are shared core registers.
// RQ21 - Unaffected flags keep their previous value.
package sfb_pkg;
  // Status flag bit positions.
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_Z_BIT = 2;
  localparam int STAT_NIB_BIT = 1;
  localparam int STAT_C_BIT = 0;
  // Value of the status register after a power-on reset.
  localparam logic [7:0] STAT_POR_VALUE = 8'h18;
  // Mask of the flag bits that writes may change.
  localparam logic [7:0] STAT_ARITH_MASK = 8'h07;
  // Data memory geometry.
  localparam int BANK_COUNT = 32;
  localparam int BANK_BYTES = 128;
  localparam int GPR_BYTES = 80;
  localparam logic [6:0] CORE_LAST = 7'h0B;
  localparam logic [6:0] PERIPH_FIRST = 7'h0C;
  localparam logic [6:0] PERIPH_LAST = 7'h1F;
  localparam logic [6:0] GPR_FIRST = 7'h20;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam logic [3:0] CORE_STATUS_IDX = 4'h3;
  localparam logic [3:0] CORE_BANKSEL_IDX = 4'h8;
  localparam logic [4:0] BANK_SEL_RESET = 5'h00;
  // Register bus map, byte addresses.
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] REG_STATUS_OFS = 4'h0;
  localparam logic [3:0] REG_BANKSEL_OFS = 4'h4;
  localparam logic [3:0] REG_RESULT_OFS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Operations offered by the execution datapath.
  typedef enum logic [2:0] {
    SFB_OP_LOGIC = 3'b000,
    SFB_OP_ADD = 3'b001,
    SFB_OP_SUB = 3'b010,
    SFB_OP_ROTR = 3'b011,
    SFB_OP_ROTL = 3'b100
  } sfb_op_t;
  // Regions of one data bank.
  typedef enum logic [2:0] {
    SFB_REG_CORE = 3'b000,
    SFB_REG_PERIPH = 3'b001,
    SFB_REG_GPR = 3'b010,
    SFB_REG_COMMON = 3'b011,
    SFB_REG_UNIMPL = 3'b100
  } sfb_region_t;
endpackage

// file: rtl/sfb_bank_decode.sv
`timescale 1ns/1ps
// Combinational decode of a banked or linear data address into its region.
module sfb_bank_decode #(
  parameter int GPR_PER_BANK = sfb_pkg::GPR_BYTES
) (
  input wire logic [4:0] bank,
  input wire logic [6:0] offset,
  input wire logic use_linear,
  input wire logic [11:0] lin_index,
  output sfb_pkg::sfb_region_t region,
  output logic [4:0] eff_bank,
  output logic [6:0] eff_offset,
  output logic [11:0] gpr_index
);
  import sfb_pkg::*;
  // Number of bytes in the whole linear general RAM window.
  localparam int LIN_SPAN = BANK_COUNT * GPR_PER_BANK;
  localparam logic [6:0] GPR_END = 7'(int'(GPR_FIRST) + GPR_PER_BANK);
  logic lin_out; // Set when a linear index lies past the window.

  // Linear addresses fold back onto a bank and an offset first.
  always_comb begin
    eff_bank = bank;
    eff_offset = offset;
    lin_out = 1'b0;
    if (use_linear) begin
      if (int'(lin_index) < LIN_SPAN) begin
        // Each bank contributes its general RAM in turn to the linear run. [RQ15]
        eff_bank = 5'(int'(lin_index) / GPR_PER_BANK);
        eff_offset = 7'(int'(GPR_FIRST) + int'(lin_index) % GPR_PER_BANK);
      end else begin
        // Past the window: fold to bank 0 and mark the access as unimplemented.
        eff_bank = 5'h00;
        eff_offset = GPR_END;
        lin_out = 1'b1;
      end
    end
  end

  // Region split of one bank, the same for all banks.
  always_comb begin
    gpr_index = 12'h000;
    if (lin_out) begin
      // Past the linear window nothing is implemented, not even common RAM. [RQ19]
      region = SFB_REG_UNIMPL;
    end else if (eff_offset <= CORE_LAST) begin
      region = SFB_REG_CORE; // [RQ20]
    end else if (eff_offset <= PERIPH_LAST) begin
      region = SFB_REG_PERIPH; // [RQ13]
    end else if (eff_offset >= COMMON_FIRST) begin
      region = SFB_REG_COMMON; // [RQ16]
    end else if (eff_offset < GPR_END) begin
      region = SFB_REG_GPR; // [RQ14]
      gpr_index = 12'(int'(eff_bank) * GPR_PER_BANK + int'(eff_offset - GPR_FIRST));
    end else begin
      region = SFB_REG_UNIMPL;
    end
  end
endmodule

// file: dv/sfb_dp_model.sv
`timescale 1ns/1ps
// Stand-in for the execution datapath: one operation pulse per instruction.
module sfb_dp_model (
  input wire logic aclk,
  output logic op_valid,
  output sfb_pkg::sfb_op_t op_code,
  output logic [7:0] op_a,
  output logic [7:0] op_b
);
  import sfb_pkg::*;
  // Idle values before the first instruction.
  initial begin
    op_valid = 1'b0;
    op_code = SFB_OP_LOGIC;
    op_a = 8'h00;
    op_b = 8'h00;
  end
  // Operands go to their inverse once taken, so stale values never look valid.
  task automatic issue(input sfb_op_t c, input logic [7:0] a, input logic [7:0] b);
    @(posedge aclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_a <= a;
    op_b <= b;
    @(posedge aclk);
    op_valid <= 1'b0;
    op_a <= ~a;
    op_b <= ~b;
  endtask
endmodule

// file: dv/tb_status_flags_bank_map.sv
`timescale 1ns/1ps
// Self-checking bench for the status flags and the bank decode.
module tb_status_flags_bank_map;
  import sfb_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] ev = 6'h00;  // Expire, clear, sleep, other reset, by watchdog, in sleep.
  logic [6:0] mem_offset = 7'h00, mem_eff_offset;
  logic mem_use_linear = 1'b0;
  logic clk_en = 1'b1, status_wr = 1'b0, bank_wr = 1'b0;
  logic [7:0] status_wdata = 8'h00;
  logic [4:0] bank_wdata = 5'h00;
  logic [11:0] mem_lin_index = 12'h000, mem_gpr_index;
  logic op_valid;
  sfb_op_t op_code;
  logic [7:0] op_a, op_b, alu_result, mem_core_rdata, core_status_flags;
  sfb_region_t mem_region;
  logic [4:0] mem_bank, bank_selector;
  int errors = 0;
  int n_compared = 0;
  always #4 aclk = ~aclk;
  sfb_dp_model sfb_dp_model_i (.aclk, .op_valid, .op_code, .op_a, .op_b);
  sfb_status_bank sfb_status_bank_i (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .op_valid, .op_code, .op_a, .op_b, .alu_result, .status_wr, .status_wdata, .bank_wr,
    .bank_wdata, .watchdog_expire(ev[0]), .watchdog_clear_instr(ev[1]), .sleep_instr(ev[2]),
    .other_reset(ev[3]), .other_reset_by_watchdog(ev[4]), .other_reset_in_sleep(ev[5]), .mem_offset,
    .mem_use_linear, .mem_lin_index, .mem_region, .mem_bank, .mem_eff_offset, .mem_gpr_index, .mem_core_rdata,
    .core_status_flags, .bank_selector);
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus write; both channels are held until taken, then the response is awaited.
  task automatic axw(input logic [3:0] ad, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    chk(r, er);
  endtask
  // Bus read of one word, compared with its response code.
  task automatic axr(input logic [3:0] ad, input logic [31:0] ed, input logic [1:0] er);
    logic a, v;
    logic [33:0] g;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      g = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
    chk(g, {er, ed});
  endtask
  // Each row: operation, operands, then expected status and result.
  task automatic t_arith();
    logic [34:0] t [8] = '{{SFB_OP_ADD, 16'h0F01, 16'h1A10}, {SFB_OP_ADD, 16'hFF01, 16'h1F00},
      {SFB_OP_SUB, 16'h1001, 16'h190F}, {SFB_OP_SUB, 16'h0001, 16'h18FF}, {SFB_OP_SUB, 16'h0505, 16'h1F00},
      {SFB_OP_LOGIC, 16'h5A00, 16'h1B5A}, {SFB_OP_ROTR, 16'h0200, 16'h1A81}, {SFB_OP_ROTL, 16'h8000, 16'h1B00}};
    @(negedge aclk);
    chk({core_status_flags, bank_selector}, {8'h18, 5'h00});
    foreach (t[i]) begin
      sfb_dp_model_i.issue(sfb_op_t'(t[i][34:32]), t[i][31:24], t[i][23:16]);
      @(negedge aclk);
      chk({core_status_flags, alu_result}, t[i][15:0]);
    end
  endtask
  // Each row: event pulses, then expected bits seven to three; low flags must stay.
  task automatic t_wake();
    logic [10:0] w [8] = '{{6'h04, 5'h02}, {6'h01, 5'h00}, {6'h02, 5'h03}, {6'h01, 5'h01},
      {6'h04, 5'h02}, {6'h28, 5'h02}, {6'h03, 5'h01}, {6'h02, 5'h03}};
    foreach (w[i]) begin
      @(posedge aclk);
      ev <= w[i][10:5];
      @(posedge aclk);
      ev <= 6'h00;
      @(negedge aclk);
      chk(core_status_flags, {w[i][4:0], 3'b011});
    end
  endtask
  // Software writes reach only the arithmetic flags; bad places are refused.
  task automatic t_bus();
    axw(REG_STATUS_OFS, 8'hFF, RESP_OKAY);
    axr(REG_STATUS_OFS, 32'h1F, RESP_OKAY);
    axw(REG_STATUS_OFS, 8'h00, RESP_OKAY);
    axr(REG_STATUS_OFS, 32'h18, RESP_OKAY);
    axw(REG_RESULT_OFS, 8'h55, RESP_SLVERR);
    axr(REG_RESULT_OFS, 32'h00, RESP_OKAY);
    axr(4'hC, 32'h0, RESP_SLVERR);
  endtask
  // Each row: bank offset, expected region and core read value in the top bank.
  task automatic t_bank();
    logic [17:0] m [7] = '{{7'h03, SFB_REG_CORE, 8'h18}, {7'h08, SFB_REG_CORE, 8'h1F}, {7'h0C, SFB_REG_PERIPH, 8'h0},
      {7'h1F, SFB_REG_PERIPH, 8'h0}, {7'h20, SFB_REG_GPR, 8'h0}, {7'h6F, SFB_REG_GPR, 8'h0}, {7'h70, SFB_REG_COMMON, 8'h0}};
    axw(REG_BANKSEL_OFS, 8'hFF, RESP_OKAY);
    axr(REG_BANKSEL_OFS, 32'h1F, RESP_OKAY);
    foreach (m[i]) begin
      @(posedge aclk);
      mem_offset <= m[i][17:11];
      @(posedge aclk);
      @(negedge aclk);
      chk({mem_bank, mem_region, mem_core_rdata}, {5'h1F, m[i][10:0]});
    end
    @(posedge aclk);
    mem_use_linear <= 1'b1;
    mem_lin_index <= 12'd2479;
    @(posedge aclk);
    @(negedge aclk);
    chk({mem_region, mem_bank, mem_eff_offset, mem_gpr_index}, {SFB_REG_GPR, 5'd30, 7'h6F, 12'd2479});
  endtask
  // Instruction writes reach only the arithmetic flags and lose to an operation; a low enable freezes the status flags.
  task automatic t_direct();
    @(posedge aclk);
    status_wr <= 1'b1;
    status_wdata <= 8'hE5;
    bank_wr <= 1'b1;
    bank_wdata <= 5'h0A;
    @(posedge aclk);
    status_wr <= 1'b0;
    bank_wr <= 1'b0;
    @(negedge aclk);
    chk({core_status_flags, bank_selector}, {8'h1D, 5'h0A});
    fork
      sfb_dp_model_i.issue(SFB_OP_ADD, 8'h01, 8'h01);
      begin
        @(posedge aclk);
        status_wr <= 1'b1;
        @(posedge aclk);
        status_wr <= 1'b0;
      end
    join
    @(negedge aclk);
    chk({core_status_flags, alu_result}, 16'h1802);
    @(posedge aclk);
    clk_en <= 1'b0;
    ev <= 6'h04;
    @(posedge aclk);
    clk_en <= 1'b1;
    ev <= 6'h00;
    @(negedge aclk);
    chk(core_status_flags, 8'h18);
  endtask
  task automatic complete_run();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_arith();
    t_wake();
    t_bus();
    t_bank();
    t_direct();
    complete_run();
  end
  // A hang counts as a mismatch.
  initial begin
    repeat (4000) @(posedge aclk);
    errors++;
    complete_run();
  end
endmodule
